// ---- design/efsc_cfg.svh ----
`ifndef EFSC_CFG_SVH
`define EFSC_CFG_SVH

// Counter geometry
`define EFSC_CNT_W       16
`define EFSC_NUM_CNT     7
`define EFSC_ADDR_W      8
`define EFSC_COLL_W      4

// Register index: address bits [7:4]; alias select: address bits [3:2]
`define EFSC_IDX_MSB     7
`define EFSC_IDX_LSB     4
`define EFSC_ALIAS_MSB   3
`define EFSC_ALIAS_LSB   2
`define EFSC_IDX_DROP    4'h0
`define EFSC_IDX_TXOK    4'h1
`define EFSC_IDX_SCOL    4'h2
`define EFSC_IDX_MCOL    4'h3
`define EFSC_IDX_RXOK    4'h4
`define EFSC_IDX_FCS     4'h5
`define EFSC_IDX_ALIGN   4'h6
`define EFSC_IDX_STATUS  4'h7
`define EFSC_IDX_MASK    4'h8

// Event and status bit positions
`define EFSC_BIT_OVFLW   0
`define EFSC_BIT_TXOK    1
`define EFSC_BIT_SCOL    2
`define EFSC_BIT_MCOL    3
`define EFSC_BIT_RXOK    4
`define EFSC_BIT_FCS     5
`define EFSC_BIT_ALIGN   6

// Collision figures for the collision counters
`define EFSC_COLL_SINGLE 1
`define EFSC_COLL_MULTI  2

// Reset values
`define EFSC_COUNT_RST   16'h0000
`define EFSC_STATUS_RST  7'h00
`define EFSC_MASK_RST    7'h00
`define EFSC_RDATA_RST   32'h0000_0000

`endif

// ---- design/efsc_pkg.sv ----
`include "efsc_cfg.svh"
`default_nettype none

package efsc_pkg;

    typedef enum logic [1:0]
    {
        EFSC_PLAIN,
        EFSC_CLR,
        EFSC_SET,
        EFSC_INV
    } efsc_alias_e;

    typedef struct packed
    {
        logic [31:0]                rdata;
        logic [`EFSC_NUM_CNT-1:0]   status;
        logic [`EFSC_NUM_CNT-1:0]   mask;
        logic                       irq;
    } efsc_state_s;

    // Applies a write through one of the four alias views
    function automatic logic [31:0] efsc_apply(input logic [31:0] old_val, input logic [31:0] wd,
                                               input efsc_alias_e op);
        logic [31:0] res;
        res = old_val;
        case (op)
            EFSC_PLAIN: res = wd;
            EFSC_CLR:   res = old_val & ~wd;
            EFSC_SET:   res = old_val | wd;
            EFSC_INV:   res = old_val ^ wd;
            default:    res = old_val;
        endcase
        return res;
    endfunction : efsc_apply

endpackage : efsc_pkg

`default_nettype wire

// ---- design/efsc_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "efsc_cfg.svh"

module efsc_counter
    import efsc_pkg::*;
#(
    parameter int WIDTH = `EFSC_CNT_W
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              inc,
    input  wire logic              rd_clr,
    input  wire logic              wr_en,
    input  wire efsc_alias_e       wr_op,
    input  wire logic [31:0]       wr_data,
    output logic      [WIDTH-1:0]  count
);

    typedef struct packed
    {
        logic [WIDTH-1:0] count;
    } efsc_cnt_s;

    efsc_cnt_s s;
    efsc_cnt_s next_s;
    logic [WIDTH-1:0] base;

    always_comb
    begin
        next_s = s;
        base   = s.count;
        if (rd_clr)
        begin
            base = '0;
        end
        if (wr_en)
        begin
            base = WIDTH'(efsc_apply(32'(s.count), wr_data, wr_op));
        end
        next_s.count = base + WIDTH'(inc);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s.count <= WIDTH'(`EFSC_COUNT_RST);
        end
        else
        begin
            s <= next_s;
        end
    end

    assign count = s.count;

endmodule : efsc_counter

`default_nettype wire

// ---- design/efsc_stats.sv ----
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "efsc_cfg.svh"

module efsc_stats
    import efsc_pkg::*;
#(
    parameter int CNT_W  = `EFSC_CNT_W,
    parameter int COLL_W = `EFSC_COLL_W
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [`EFSC_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [3:0]               reg_rd_be,
    output logic      [31:0]              reg_rdata,
    input  wire logic                     rx_overrun_drop,
    input  wire logic                     tx_frame_ok,
    input  wire logic [COLL_W-1:0]        tx_collisions,
    input  wire logic                     rx_frame_done,
    input  wire logic                     rx_filter_accept,
    input  wire logic                     rx_fcs_error,
    input  wire logic                     rx_dribble,
    output logic                          irq
);

    localparam int N = `EFSC_NUM_CNT;

    efsc_state_s               s;
    efsc_state_s               next_s;
    logic        [N-1:0]       ev;
    logic        [N-1:0]       rd_clr_vec;
    logic        [N-1:0]       wr_vec;
    logic        [CNT_W-1:0]   cnt [N];
    logic        [3:0]         idx;
    efsc_alias_e               op;
    logic                      be_low;

    function automatic logic [3:0] reg_index(input logic [`EFSC_ADDR_W-1:0] a);
        return a[`EFSC_IDX_MSB:`EFSC_IDX_LSB];
    endfunction : reg_index

    function automatic efsc_alias_e alias_of(input logic [`EFSC_ADDR_W-1:0] a);
        return efsc_alias_e'(a[`EFSC_ALIAS_MSB:`EFSC_ALIAS_LSB]);
    endfunction : alias_of

    assign idx    = reg_index(reg_addr);
    assign op     = alias_of(reg_addr);
    assign be_low = (reg_rd_be[1:0] == 2'h0);

    assign ev[`EFSC_BIT_OVFLW] = rx_overrun_drop;
    assign ev[`EFSC_BIT_TXOK]  = tx_frame_ok;
    assign ev[`EFSC_BIT_SCOL]  = tx_frame_ok && (tx_collisions == COLL_W'(`EFSC_COLL_SINGLE));
    assign ev[`EFSC_BIT_MCOL]  = tx_frame_ok && (tx_collisions >= COLL_W'(`EFSC_COLL_MULTI));
    assign ev[`EFSC_BIT_RXOK]  = rx_frame_done && rx_filter_accept && !rx_fcs_error;
    assign ev[`EFSC_BIT_FCS]   = rx_frame_done && rx_fcs_error && !rx_dribble;
    assign ev[`EFSC_BIT_ALIGN] = rx_frame_done && rx_fcs_error && rx_dribble;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cnt
            assign rd_clr_vec[g] = reg_rd && (idx == 4'(g)) && !be_low;
            assign wr_vec[g]     = reg_wr && (idx == 4'(g));
            efsc_counter #(
                .WIDTH   (CNT_W)
            ) u_cnt (
                .clk     (clk),
                .rst     (rst),
                .inc     (ev[g]),
                .rd_clr  (rd_clr_vec[g]),
                .wr_en   (wr_vec[g]),
                .wr_op   (op),
                .wr_data (reg_wdata),
                .count   (cnt[g])
            );
        end
    endgenerate

    always_comb
    begin
        next_s       = s;
        next_s.rdata = `EFSC_RDATA_RST;
        if (reg_rd)
        begin
            if (idx < 4'(N))
            begin
                next_s.rdata = 32'(cnt[idx[2:0]]);
            end
            else if (idx == `EFSC_IDX_STATUS)
            begin
                next_s.rdata = 32'(s.status);
            end
            else if (idx == `EFSC_IDX_MASK)
            begin
                next_s.rdata = 32'(s.mask);
            end
        end
        if (reg_wr && (idx == `EFSC_IDX_STATUS))
        begin
            // ones clear on plain and clear views
            next_s.status = N'(efsc_apply(32'(s.status), reg_wdata,
                                          (op == EFSC_PLAIN) ? EFSC_CLR : op));
        end
        if (reg_wr && (idx == `EFSC_IDX_MASK))
        begin
            next_s.mask = N'(efsc_apply(32'(s.mask), reg_wdata, op));
        end
        next_s.status = next_s.status | ev;
        next_s.irq    = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s.rdata  <= `EFSC_RDATA_RST;
            s.status <= `EFSC_STATUS_RST;
            s.mask   <= `EFSC_MASK_RST;
            s.irq    <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign irq       = s.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic quiet_drop;
    logic quiet_txok;
    logic quiet_scol;
    logic quiet_mcol;
    logic quiet_rxok;
    logic quiet_fcs;
    logic quiet_align;
    logic ovf_clr_wr;

    assign quiet_drop  = !rd_clr_vec[`EFSC_BIT_OVFLW] && !wr_vec[`EFSC_BIT_OVFLW];
    assign quiet_txok  = !rd_clr_vec[`EFSC_BIT_TXOK] && !wr_vec[`EFSC_BIT_TXOK];
    assign quiet_scol  = !rd_clr_vec[`EFSC_BIT_SCOL] && !wr_vec[`EFSC_BIT_SCOL];
    assign quiet_mcol  = !rd_clr_vec[`EFSC_BIT_MCOL] && !wr_vec[`EFSC_BIT_MCOL];
    assign quiet_rxok  = !rd_clr_vec[`EFSC_BIT_RXOK] && !wr_vec[`EFSC_BIT_RXOK];
    assign quiet_fcs   = !rd_clr_vec[`EFSC_BIT_FCS] && !wr_vec[`EFSC_BIT_FCS];
    assign quiet_align = !rd_clr_vec[`EFSC_BIT_ALIGN] && !wr_vec[`EFSC_BIT_ALIGN];
    assign ovf_clr_wr  = reg_wr && (idx == `EFSC_IDX_STATUS) && reg_wdata[`EFSC_BIT_OVFLW]
                         && ((op == EFSC_PLAIN) || (op == EFSC_CLR));

    a_drop_count_step: assert property (
        rx_overrun_drop && quiet_drop |=> cnt[`EFSC_BIT_OVFLW] == CNT_W'($past(cnt[`EFSC_BIT_OVFLW]) + 1'b1))
        else $error("dropped frame count did not step");

    a_ovf_flag_set: assert property (
        rx_overrun_drop |=> s.status[`EFSC_BIT_OVFLW] && (irq || !s.mask[`EFSC_BIT_OVFLW]))
        else $error("overflow flag not set by overrun");

    a_read_clears_count: assert property (
        rd_clr_vec[`EFSC_BIT_TXOK] && !ev[`EFSC_BIT_TXOK] |=> cnt[`EFSC_BIT_TXOK] == '0
            && reg_rdata == 32'($past(cnt[`EFSC_BIT_TXOK])))
        else $error("read did not clear counter");

    a_be_low_keeps: assert property (
        reg_rd && be_low && (idx == `EFSC_IDX_FCS) && !ev[`EFSC_BIT_FCS] |=> $stable(cnt[`EFSC_BIT_FCS]))
        else $error("read with low byte enables changed counter");

    a_txok_count_step: assert property (
        tx_frame_ok && quiet_txok |=> cnt[`EFSC_BIT_TXOK] == CNT_W'($past(cnt[`EFSC_BIT_TXOK]) + 1'b1))
        else $error("tx ok count did not step");

    a_scol_count_step: assert property (
        quiet_scol |=> cnt[`EFSC_BIT_SCOL] == CNT_W'($past(cnt[`EFSC_BIT_SCOL])
            + ($past(tx_frame_ok) && $past(tx_collisions) == COLL_W'(1))))
        else $error("single collision count wrong");

    a_mcol_count_step: assert property (
        quiet_mcol |=> cnt[`EFSC_BIT_MCOL] == CNT_W'($past(cnt[`EFSC_BIT_MCOL])
            + ($past(tx_frame_ok) && $past(tx_collisions) > COLL_W'(1))))
        else $error("multi collision count wrong");

    a_rxok_count_step: assert property (
        rx_frame_done && rx_filter_accept && !rx_fcs_error && quiet_rxok
            |=> cnt[`EFSC_BIT_RXOK] == CNT_W'($past(cnt[`EFSC_BIT_RXOK]) + 1'b1))
        else $error("rx ok count did not step");

    a_rxok_hold_err: assert property (
        rx_frame_done && rx_fcs_error && quiet_rxok |=> $stable(cnt[`EFSC_BIT_RXOK]))
        else $error("rx ok counted an errored frame");

    a_fcs_count_step: assert property (
        quiet_fcs |=> cnt[`EFSC_BIT_FCS] == CNT_W'($past(cnt[`EFSC_BIT_FCS])
            + ($past(rx_frame_done) && $past(rx_fcs_error) && !$past(rx_dribble))))
        else $error("fcs error count wrong");

    a_upper_half_zero: assert property (
        reg_rd && (idx < 4'(N)) |=> reg_rdata[31:16] == 16'h0000 ##1 reg_rdata == 32'h0000_0000 || $past(reg_rd))
        else $error("counter upper half not zero");

    a_align_count_step: assert property (
        quiet_align |=> cnt[`EFSC_BIT_ALIGN] == CNT_W'($past(cnt[`EFSC_BIT_ALIGN])
            + ($past(rx_frame_done) && $past(rx_fcs_error) && $past(rx_dribble))))
        else $error("alignment count wrong");

    a_ovf_flag_hold: assert property (
        s.status[`EFSC_BIT_OVFLW] && !ovf_clr_wr |=> s.status[`EFSC_BIT_OVFLW])
        else $error("overflow flag dropped without clear");

    a_clear_keeps_event: assert property (
        rd_clr_vec[`EFSC_BIT_OVFLW] && rx_overrun_drop |=> cnt[`EFSC_BIT_OVFLW] == CNT_W'(1))
        else $error("event lost on clearing read");

    a_drop_count_idle: assert property (
        !rx_overrun_drop && quiet_drop |=> $stable(cnt[`EFSC_BIT_OVFLW]))
        else $error("dropped frame count moved without event");

    a_ovf_event_wins: assert property (
        rx_overrun_drop && ovf_clr_wr |=> s.status[`EFSC_BIT_OVFLW])
        else $error("overflow flag lost to a clear");

    a_read_returns_old: assert property (
        rd_clr_vec[`EFSC_BIT_RXOK] |=> reg_rdata == 32'($past(cnt[`EFSC_BIT_RXOK])))
        else $error("clearing read returned wrong value");

    a_txok_count_idle: assert property (
        !tx_frame_ok && quiet_txok |=> $stable(cnt[`EFSC_BIT_TXOK]))
        else $error("tx ok count moved without event");

    a_rxok_count_idle: assert property (
        !rx_frame_done && quiet_rxok |=> $stable(cnt[`EFSC_BIT_RXOK]))
        else $error("rx ok count moved without frame");

    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read");

    a_ovf_flag_clear: assert property (
        ovf_clr_wr && !rx_overrun_drop |=> !s.status[`EFSC_BIT_OVFLW])
        else $error("overflow flag not cleared by write");

    a_txok_clear_keeps: assert property (
        rd_clr_vec[`EFSC_BIT_TXOK] && tx_frame_ok |=> cnt[`EFSC_BIT_TXOK] == CNT_W'(1))
        else $error("tx event lost on clearing read");

    c_clear_with_event: cover property (rd_clr_vec[`EFSC_BIT_RXOK] && ev[`EFSC_BIT_RXOK]);
    c_irq_raised: cover property (!irq ##1 irq);
    c_multi_collision: cover property (ev[`EFSC_BIT_MCOL]);
    c_align_error: cover property (ev[`EFSC_BIT_ALIGN] ##[1:20] rd_clr_vec[`EFSC_BIT_ALIGN]);
    c_masked_read: cover property (reg_rd && be_low && (idx < 4'(N)));

endmodule : efsc_stats

`default_nettype wire

// ---- verif/test_efsc_stats.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "efsc_cfg.svh"

`define TB_CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); \
        end \
    end

module test_efsc_stats
    import efsc_pkg::*;
;
    logic                     clk;
    logic                     rst;
    logic [`EFSC_ADDR_W-1:0]  reg_addr;
    logic [31:0]              reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [3:0]               reg_rd_be;
    logic [31:0]              reg_rdata;
    logic                     rx_overrun_drop;
    logic                     tx_frame_ok;
    logic [`EFSC_COLL_W-1:0]  tx_collisions;
    logic                     rx_frame_done;
    logic                     rx_filter_accept;
    logic                     rx_fcs_error;
    logic                     rx_dribble;
    logic                     irq;
    int                       miscompares;
    int                       num_checks;

    efsc_stats efsc_stats_inst
    (
        .clk              (clk),
        .rst              (rst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rd_be        (reg_rd_be),
        .reg_rdata        (reg_rdata),
        .rx_overrun_drop  (rx_overrun_drop),
        .tx_frame_ok      (tx_frame_ok),
        .tx_collisions    (tx_collisions),
        .rx_frame_done    (rx_frame_done),
        .rx_filter_accept (rx_filter_accept),
        .rx_fcs_error     (rx_fcs_error),
        .rx_dribble       (rx_dribble),
        .irq              (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
        @(posedge clk);
        reg_rd    <= 1'b1;
        reg_addr  <= a;
        reg_rd_be <= be;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1;
        `TB_CHK(reg_rdata, exp)
    endtask : rd

    task automatic drop();
        @(posedge clk);
        rx_overrun_drop <= 1'b1;
        @(posedge clk);
        rx_overrun_drop <= 1'b0;
        #1;
    endtask : drop

    task automatic tx(input logic [3:0] coll);
        @(posedge clk);
        tx_frame_ok   <= 1'b1;
        tx_collisions <= coll;
        @(posedge clk);
        tx_frame_ok   <= 1'b0;
    endtask : tx

    task automatic rx(input logic acc, input logic fcs, input logic drib);
        @(posedge clk);
        rx_frame_done    <= 1'b1;
        rx_filter_accept <= acc;
        rx_fcs_error     <= fcs;
        rx_dribble       <= drib;
        @(posedge clk);
        rx_frame_done    <= 1'b0;
    endtask : rx

    // Reset values and unmapped places
    task automatic test_reset();
        for (int i = 0; i < 9; i++)
            rd(8'(i * 16), 4'h0, 32'h0000_0000);
        wr(8'h90, 32'hFFFF_FFFF);
        rd(8'h90, 4'hF, 32'h0000_0000);
        rd(8'hF0, 4'hF, 32'h0000_0000);
    endtask : test_reset

    // Overrun count, sticky flag, interrupt
    task automatic test_overrun();
        wr(8'h88, 32'h0000_0001);
        drop();
        `TB_CHK(irq, 1'b1)
        drop();
        rd(8'h00, 4'hF, 32'h0000_0002);
        rd(8'h00, 4'hF, 32'h0000_0000);
        repeat (3) @(posedge clk);
        rd(8'h70, 4'h0, 32'h0000_0001);
        `TB_CHK(irq, 1'b1)
        wr(8'h74, 32'h0000_0001);
        #1;
        `TB_CHK(irq, 1'b0)
        rd(8'h70, 4'h0, 32'h0000_0000);
        wr(8'h84, 32'h0000_0001);
        drop();
        `TB_CHK(irq, 1'b0)
        rd(8'h70, 4'h0, 32'h0000_0001);
        wr(8'h74, 32'h0000_0001);
        // Overrun meets a flag clear in one cycle
        @(posedge clk);
        reg_wr          <= 1'b1;
        reg_addr        <= 8'h74;
        reg_wdata       <= 32'h0000_0001;
        rx_overrun_drop <= 1'b1;
        @(posedge clk);
        reg_wr          <= 1'b0;
        rx_overrun_drop <= 1'b0;
        rd(8'h70, 4'h0, 32'h0000_0001);
        rd(8'h00, 4'hF, 32'h0000_0002);
    endtask : test_overrun

    // Transmit and collision counts
    task automatic test_tx();
        tx(4'h0);
        tx(4'h1);
        tx(4'h2);
        tx(4'h9);
        rd(8'h10, 4'hF, 32'h0000_0004);
        rd(8'h20, 4'hF, 32'h0000_0001);
        rd(8'h30, 4'hF, 32'h0000_0002);
    endtask : test_tx

    // Receive good, FCS and alignment counts
    task automatic test_rx();
        rx(1'b1, 1'b0, 1'b0);
        rx(1'b1, 1'b0, 1'b0);
        rx(1'b0, 1'b0, 1'b0);
        rx(1'b1, 1'b1, 1'b0);
        rx(1'b1, 1'b1, 1'b1);
        rd(8'h40, 4'hF, 32'h0000_0002);
        rd(8'h50, 4'hF, 32'h0000_0001);
        rd(8'h60, 4'hF, 32'h0000_0001);
    endtask : test_rx

    // Byte enables and event during clearing read
    task automatic test_clear();
        repeat (3) tx(4'h0);
        rd(8'h10, 4'hC, 32'h0000_0003);
        rd(8'h10, 4'h0, 32'h0000_0003);
        rd(8'h10, 4'h2, 32'h0000_0003);
        rd(8'h10, 4'hC, 32'h0000_0000);
        tx(4'h0);
        @(posedge clk);
        reg_rd        <= 1'b1;
        reg_addr      <= 8'h10;
        reg_rd_be     <= 4'h1;
        tx_frame_ok   <= 1'b1;
        tx_collisions <= 4'h0;
        @(posedge clk);
        reg_rd        <= 1'b0;
        tx_frame_ok   <= 1'b0;
        #1;
        `TB_CHK(reg_rdata, 32'h0000_0001)
        rd(8'h10, 4'hF, 32'h0000_0001);
    endtask : test_clear

    // Upper half, wrap and alias views
    task automatic test_alias();
        wr(8'h28, 32'hFFFF_FFFF);
        rd(8'h20, 4'hC, 32'h0000_FFFF);
        tx(4'h1);
        rd(8'h20, 4'hC, 32'h0000_0000);
        wr(8'h28, 32'h0000_00F0);
        wr(8'h2C, 32'h0000_0011);
        wr(8'h24, 32'h0000_0001);
        rd(8'h20, 4'hF, 32'h0000_00E0);
        rd(8'h20, 4'hF, 32'h0000_0000);
    endtask : test_alias

    // Reset in mid-run clears counts, flags and mask
    task automatic test_midreset();
        wr(8'h88, 32'h0000_0001);
        drop();
        tx(4'h1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `TB_CHK(irq, 1'b0)
        rd(8'h00, 4'hF, 32'h0000_0000);
        rd(8'h20, 4'hF, 32'h0000_0000);
        rd(8'h70, 4'h0, 32'h0000_0000);
        rd(8'h80, 4'h0, 32'h0000_0000);
        wr(8'h88, 32'h0000_0001);
        drop();
        `TB_CHK(irq, 1'b1)
        rd(8'h00, 4'hF, 32'h0000_0001);
    endtask : test_midreset

    initial
    begin
        miscompares      = 0;
        num_checks       = 0;
        rst              = 1'b1;
        reg_addr         = '0;
        reg_wdata        = '0;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        reg_rd_be        = 4'h0;
        rx_overrun_drop  = 1'b0;
        tx_frame_ok      = 1'b0;
        tx_collisions    = '0;
        rx_frame_done    = 1'b0;
        rx_filter_accept = 1'b0;
        rx_fcs_error     = 1'b0;
        rx_dribble       = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_overrun();
        test_tx();
        test_rx();
        test_clear();
        test_alias();
        test_midreset();
        repeat (2) @(posedge clk);
        summarize();
    end

    initial
    begin
        #50000;
        miscompares++;
        summarize();
    end

endmodule : test_efsc_stats

`default_nettype wire
